// ===== logic/tcu_pkg.sv
// Package with register map, bit positions and types of the timer/counter unit
package tcu_pkg;

  // Register byte addresses (Wishbone, one address each, not all word aligned)
  localparam logic [7:0] TCU_ADDR_RUN_CTRL = 8'h88;
  localparam logic [7:0] TCU_ADDR_T0_LOW   = 8'h8a;
  localparam logic [7:0] TCU_ADDR_T0_HIGH  = 8'h8c;
  localparam logic [7:0] TCU_ADDR_T1_LOW   = 8'h90;
  localparam logic [7:0] TCU_ADDR_T1_HIGH  = 8'h94;
  localparam logic [7:0] TCU_ADDR_T2_CTRL  = 8'hc8;
  localparam logic [7:0] TCU_ADDR_RCAP_LOW = 8'hcc;
  localparam logic [7:0] TCU_ADDR_RCAP_HI  = 8'hd0;
  localparam logic [7:0] TCU_ADDR_T2_LOW   = 8'hd4;
  localparam logic [7:0] TCU_ADDR_T2_HIGH  = 8'hd8;
  localparam logic [7:0] TCU_ADDR_VECTOR   = 8'hdc;
  localparam logic [7:0] TCU_ADDR_T01_MODE = 8'he0;

  // Timer run control bit positions
  localparam int TCU_TF1 = 7;
  localparam int TCU_TR1 = 6;
  localparam int TCU_TF0 = 5;
  localparam int TCU_TR0 = 4;
  localparam int TCU_IE1 = 3;
  localparam int TCU_IT1 = 2;
  localparam int TCU_IE0 = 1;
  localparam int TCU_IT0 = 0;

  // Third timer control bit positions
  localparam int TCU_TF2   = 7;
  localparam int TCU_EXTERNAL_TRIGGER_FLAG  = 6;
  localparam int TCU_RCLK  = 5;
  localparam int TCU_TRANSMIT_BAUD_CLOCK_SELECT  = 4;
  localparam int TCU_EXTERNAL_TRIGGER_ENABLE = 3;
  localparam int TCU_TR2   = 2;
  localparam int TCU_CAPTURE_SELECT  = 0;

  // Vector acknowledge bits (write one to signal vectoring)
  localparam int TCU_VEC_EXT0 = 0;
  localparam int TCU_VEC_T0   = 1;
  localparam int TCU_VEC_EXT1 = 2;
  localparam int TCU_VEC_T1   = 3;

  // Reset values and other constants
  localparam logic [7:0]  TCU_BYTE_RESET = 8'h00;
  localparam logic [15:0] TCU_WORD_RESET = 16'h0000;
  localparam logic [15:0] TCU_WORD_ONE   = 16'h0001;
  localparam logic [15:0] TCU_WORD_MAX   = 16'hffff;
  localparam logic [7:0]  TCU_BYTE_MAX   = 8'hff;
  localparam logic [31:0] TCU_UNMAPPED   = 32'h0000_0000;

  // Third timer operating modes
  typedef enum logic [1:0] {
    TCU_MODE_OFF,
    TCU_MODE_RELOAD,
    TCU_MODE_CAPTURE,
    TCU_MODE_BAUD
  } tcu_mode_e;

  // Wishbone request bundle
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } tcu_wb_req_s;

endpackage

// ===== logic/tcu_fall_detect.sv
// Two-flop synchroniser with falling-edge detector for one pin
`timescale 1ns/100ps
`default_nettype none
module tcu_fall_detect (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Pin and results
  input  wire logic pin_i,
  output logic      level_o,
  output logic      fall_o
);

  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  // Synchroniser chain plus one history stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      prev_reg <= 1'b1;
    end else begin
      meta_reg <= pin_i;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // High in one sample, low in the next
  assign level_o = sync_reg;
  assign fall_o  = prev_reg & ~sync_reg;

endmodule
`default_nettype wire

// ===== logic/tcu_top.sv
// Timer/counter unit with Wishbone register slave
// Overview of operation
// - Timer one overflow sets flag bit 7; vectoring clears it.
// - Timer zero overflow sets flag bit 5; vectoring clears it.
// - Timers one and zero count only while run bits 6 and 4 set.
// - Ext irq one flag set by falling edge or low level per type bit.
// - Level mode flags follow the pin and are not cleared by vectoring.
// - Trigger-type bit set selects edge, clear selects low level.
// - Ext irq zero flag bit 1; vectoring clears it only in edge mode.
// - Basic timers are one 16-bit counter, or the low byte counting alone.
// - Third timer mode: off, baud, capture or autoreload from its bits.
// - Autoreload rollover sets overflow flag and reloads from capture regs.
// - Autoreload with trigger enable: input fall reloads and sets flag.
// - Capture mode without trigger enable is a plain 16-bit timer.
// - Capture mode with trigger enable: input fall captures count, sets flag.
// - External trigger flag requests interrupt like overflow flag.
// - Baud mode never sets the third timer overflow flag.
// - Baud mode still sets the external trigger flag on input fall.
// - Baud mode increments every two core clocks.
// - Receive and transmit baud selects act independently.
`timescale 1ns/100ps
`default_nettype none
module tcu_top
  import tcu_pkg::*;
#(
  parameter int MACHINE_DIV = 12
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // External pins
  input  wire logic        ext_irq_zero_pin_i,
  input  wire logic        ext_irq_one_pin_i,
  input  wire logic        external_trigger_input_i,
  // Interrupt requests and baud ticks
  output logic             ext_irq_zero_req_o,
  output logic             timer_zero_req_o,
  output logic             ext_irq_one_req_o,
  output logic             timer_one_req_o,
  output logic             third_timer_req_o,
  output logic             rx_baud_tick_o,
  output logic             tx_baud_tick_o
);

  tcu_wb_req_s req;
  logic        ack_reg;
  logic [31:0] dat_reg;
  logic        wr;
  logic        rd;

  // Control and count registers
  logic [7:0]  timer_run_control_reg;
  logic [7:0]  third_timer_control_reg;
  logic [15:0] t0_cnt_reg;
  logic [15:0] t1_cnt_reg;
  logic [15:0] t2_cnt_reg;
  logic [15:0] rcap_reg;
  logic [1:0]  t01_mode_reg;
  logic [7:0]  mcyc_cnt_reg;
  logic        half_reg;
  logic [7:0]  wr_byte;
  logic [3:0]  vec_ack;

  // Pin edge and level signals
  logic        irq0_level;
  logic        irq0_fall;
  logic        irq1_level;
  logic        irq1_fall;
  logic        trig_fall;

  // Timer events
  logic        mcyc_tick;
  logic        t0_ovf;
  logic        t1_ovf;
  logic        t2_tick;
  logic        t2_ovf;
  tcu_mode_e   t2_mode;

  assign req = '{cyc: cyc_i, stb: stb_i, we: we_i, adr: adr_i,
                 sel: sel_i, dat: dat_i};

  // Bus strobes, one access per request
  assign wr      = req.cyc & req.stb & req.we & ~ack_reg & req.sel[0];
  assign rd      = req.cyc & req.stb & ~req.we & ~ack_reg;
  assign wr_byte = req.dat[7:0];
  assign vec_ack = (wr && req.adr == TCU_ADDR_VECTOR) ? wr_byte[3:0]
                                                      : 4'h0;

  // Pin synchronisers
  tcu_fall_detect u_irq0 (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .pin_i  (ext_irq_zero_pin_i),
    .level_o(irq0_level),
    .fall_o (irq0_fall)
  );

  tcu_fall_detect u_irq1 (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .pin_i  (ext_irq_one_pin_i),
    .level_o(irq1_level),
    .fall_o (irq1_fall)
  );

  tcu_fall_detect u_trig (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .pin_i  (external_trigger_input_i),
    .level_o(),
    .fall_o (trig_fall)
  );

  // Machine cycle prescaler and baud half-rate toggle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mcyc_cnt_reg <= TCU_BYTE_RESET;
      half_reg     <= 1'b0;
    end else begin
      half_reg <= ~half_reg;
      if (mcyc_cnt_reg == 8'(MACHINE_DIV - 1)) begin
        mcyc_cnt_reg <= TCU_BYTE_RESET;
      end else begin
        mcyc_cnt_reg <= mcyc_cnt_reg + 8'h01;
      end
    end
  end
  assign mcyc_tick = (mcyc_cnt_reg == 8'(MACHINE_DIV - 1));

  // Third timer mode decode
  always_comb begin
    if (!third_timer_control_reg[TCU_TR2]) begin
      t2_mode = TCU_MODE_OFF;
    end else if (third_timer_control_reg[TCU_RCLK] |
                 third_timer_control_reg[TCU_TRANSMIT_BAUD_CLOCK_SELECT]) begin
      t2_mode = TCU_MODE_BAUD;
    end else if (third_timer_control_reg[TCU_CAPTURE_SELECT]) begin
      t2_mode = TCU_MODE_CAPTURE;
    end else begin
      t2_mode = TCU_MODE_RELOAD;
    end
  end

  // Basic timer overflow: 16-bit or low byte alone
  always_comb begin
    t0_ovf = 1'b0;
    t1_ovf = 1'b0;
    if (timer_run_control_reg[TCU_TR0] && mcyc_tick) begin
      t0_ovf = t01_mode_reg[0] ? (t0_cnt_reg[7:0] == TCU_BYTE_MAX)
                               : (t0_cnt_reg == TCU_WORD_MAX);
    end
    if (timer_run_control_reg[TCU_TR1] && mcyc_tick) begin
      t1_ovf = t01_mode_reg[1] ? (t1_cnt_reg[7:0] == TCU_BYTE_MAX)
                               : (t1_cnt_reg == TCU_WORD_MAX);
    end
  end

  // Timer zero count, software write wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      t0_cnt_reg <= TCU_WORD_RESET;
    end else if (wr && req.adr == TCU_ADDR_T0_LOW) begin
      t0_cnt_reg[7:0] <= wr_byte;
    end else if (wr && req.adr == TCU_ADDR_T0_HIGH) begin
      t0_cnt_reg[15:8] <= wr_byte;
    end else if (timer_run_control_reg[TCU_TR0] && mcyc_tick) begin
      if (t01_mode_reg[0]) begin
        t0_cnt_reg[7:0] <= t0_cnt_reg[7:0] + 8'h01;
      end else begin
        t0_cnt_reg <= t0_cnt_reg + TCU_WORD_ONE;
      end
    end
  end

  // Timer one count, software write wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      t1_cnt_reg <= TCU_WORD_RESET;
    end else if (wr && req.adr == TCU_ADDR_T1_LOW) begin
      t1_cnt_reg[7:0] <= wr_byte;
    end else if (wr && req.adr == TCU_ADDR_T1_HIGH) begin
      t1_cnt_reg[15:8] <= wr_byte;
    end else if (timer_run_control_reg[TCU_TR1] && mcyc_tick) begin
      if (t01_mode_reg[1]) begin
        t1_cnt_reg[7:0] <= t1_cnt_reg[7:0] + 8'h01;
      end else begin
        t1_cnt_reg <= t1_cnt_reg + TCU_WORD_ONE;
      end
    end
  end

  // Basic timer byte/word mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      t01_mode_reg <= 2'b00;
    end else if (wr && req.adr == TCU_ADDR_T01_MODE) begin
      t01_mode_reg <= wr_byte[1:0];
    end
  end

  // Run control flags: set by hardware, cleared on vectoring except level-mode irq flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_run_control_reg <= TCU_BYTE_RESET;
    end else begin
      if (wr && req.adr == TCU_ADDR_RUN_CTRL) begin
        timer_run_control_reg <= wr_byte;
      end else begin
        // Timer one flag
        if (t1_ovf) begin
          timer_run_control_reg[TCU_TF1] <= 1'b1;
        end else if (vec_ack[TCU_VEC_T1]) begin
          timer_run_control_reg[TCU_TF1] <= 1'b0;
        end
        // Timer zero flag
        if (t0_ovf) begin
          timer_run_control_reg[TCU_TF0] <= 1'b1;
        end else if (vec_ack[TCU_VEC_T0]) begin
          timer_run_control_reg[TCU_TF0] <= 1'b0;
        end
        // Ext irq one: edge or level per type bit
        if (timer_run_control_reg[TCU_IT1]) begin
          if (irq1_fall) begin
            timer_run_control_reg[TCU_IE1] <= 1'b1;
          end else if (vec_ack[TCU_VEC_EXT1]) begin
            timer_run_control_reg[TCU_IE1] <= 1'b0;
          end
        end else begin
          timer_run_control_reg[TCU_IE1] <= ~irq1_level;
        end
        // Ext irq zero: edge or level per type bit
        if (timer_run_control_reg[TCU_IT0]) begin
          if (irq0_fall) begin
            timer_run_control_reg[TCU_IE0] <= 1'b1;
          end else if (vec_ack[TCU_VEC_EXT0]) begin
            timer_run_control_reg[TCU_IE0] <= 1'b0;
          end
        end else begin
          timer_run_control_reg[TCU_IE0] <= ~irq0_level;
        end
      end
    end
  end

  // Third timer increment rate
  assign t2_tick = (t2_mode == TCU_MODE_BAUD) ? half_reg
                 : ((t2_mode != TCU_MODE_OFF) & mcyc_tick);
  assign t2_ovf  = t2_tick & (t2_cnt_reg == TCU_WORD_MAX);

  // Third timer count with reload
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      t2_cnt_reg <= TCU_WORD_RESET;
    end else if (wr && req.adr == TCU_ADDR_T2_LOW) begin
      t2_cnt_reg[7:0] <= wr_byte;
    end else if (wr && req.adr == TCU_ADDR_T2_HIGH) begin
      t2_cnt_reg[15:8] <= wr_byte;
    end else if (t2_mode == TCU_MODE_RELOAD &&
                 third_timer_control_reg[TCU_EXTERNAL_TRIGGER_ENABLE] && trig_fall) begin
      t2_cnt_reg <= rcap_reg;
    end else if (t2_ovf && t2_mode != TCU_MODE_CAPTURE) begin
      t2_cnt_reg <= rcap_reg;
    end else if (t2_tick) begin
      t2_cnt_reg <= t2_cnt_reg + TCU_WORD_ONE;
    end
  end

  // Reload/capture registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rcap_reg <= TCU_WORD_RESET;
    end else if (wr && req.adr == TCU_ADDR_RCAP_LOW) begin
      rcap_reg[7:0] <= wr_byte;
    end else if (wr && req.adr == TCU_ADDR_RCAP_HI) begin
      rcap_reg[15:8] <= wr_byte;
    end else if (t2_mode == TCU_MODE_CAPTURE &&
                 third_timer_control_reg[TCU_EXTERNAL_TRIGGER_ENABLE] && trig_fall) begin
      rcap_reg <= t2_cnt_reg;
    end
  end

  // Third timer control and flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      third_timer_control_reg <= TCU_BYTE_RESET;
    end else if (wr && req.adr == TCU_ADDR_T2_CTRL) begin
      third_timer_control_reg <= wr_byte;
    end else begin
      if (t2_ovf && t2_mode != TCU_MODE_BAUD) begin
        third_timer_control_reg[TCU_TF2] <= 1'b1;
      end
      if (third_timer_control_reg[TCU_EXTERNAL_TRIGGER_ENABLE] && trig_fall &&
          t2_mode != TCU_MODE_OFF) begin
        third_timer_control_reg[TCU_EXTERNAL_TRIGGER_FLAG] <= 1'b1;
      end
    end
  end

  // Baud ticks per direction
  assign rx_baud_tick_o = t2_ovf & third_timer_control_reg[TCU_RCLK];
  assign tx_baud_tick_o = t2_ovf & third_timer_control_reg[TCU_TRANSMIT_BAUD_CLOCK_SELECT];

  // Interrupt requests
  assign ext_irq_zero_req_o = timer_run_control_reg[TCU_IE0];
  assign timer_zero_req_o   = timer_run_control_reg[TCU_TF0];
  assign ext_irq_one_req_o  = timer_run_control_reg[TCU_IE1];
  assign timer_one_req_o    = timer_run_control_reg[TCU_TF1];
  assign third_timer_req_o  = third_timer_control_reg[TCU_TF2] |
                              third_timer_control_reg[TCU_EXTERNAL_TRIGGER_FLAG];

  // Read mux and single-cycle acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= TCU_UNMAPPED;
    end else begin
      ack_reg <= req.cyc & req.stb & ~ack_reg;
      if (rd) begin
        unique case (req.adr)
          TCU_ADDR_RUN_CTRL: dat_reg <= {24'h00_0000, timer_run_control_reg};
          TCU_ADDR_T0_LOW:   dat_reg <= {24'h00_0000, t0_cnt_reg[7:0]};
          TCU_ADDR_T0_HIGH:  dat_reg <= {24'h00_0000, t0_cnt_reg[15:8]};
          TCU_ADDR_T1_LOW:   dat_reg <= {24'h00_0000, t1_cnt_reg[7:0]};
          TCU_ADDR_T1_HIGH:  dat_reg <= {24'h00_0000, t1_cnt_reg[15:8]};
          TCU_ADDR_T2_CTRL:  dat_reg <= {24'h00_0000, third_timer_control_reg};
          TCU_ADDR_RCAP_LOW: dat_reg <= {24'h00_0000, rcap_reg[7:0]};
          TCU_ADDR_RCAP_HI:  dat_reg <= {24'h00_0000, rcap_reg[15:8]};
          TCU_ADDR_T2_LOW:   dat_reg <= {24'h00_0000, t2_cnt_reg[7:0]};
          TCU_ADDR_T2_HIGH:  dat_reg <= {24'h00_0000, t2_cnt_reg[15:8]};
          TCU_ADDR_T01_MODE: dat_reg <= {30'h0000_0000, t01_mode_reg};
          default:           dat_reg <= TCU_UNMAPPED;
        endcase
      end
    end
  end

  assign ack_o = ack_reg;
  assign dat_o = dat_reg;

endmodule
`default_nettype wire

// ===== tb/tcu_asserts.sv
// Port-level assertions for the timer/counter unit
`timescale 1ns/100ps
`default_nettype none
module tcu_asserts
  import tcu_pkg::*;
#(
  parameter int MACHINE_DIV = 12
) (
  // Clock, reset and register bus
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  // Pins
  input wire logic        ext_irq_zero_pin_i,
  input wire logic        ext_irq_one_pin_i,
  // Requests and ticks
  input wire logic        ext_irq_zero_req_o,
  input wire logic        timer_zero_req_o,
  input wire logic        ext_irq_one_req_o,
  input wire logic        rx_baud_tick_o,
  input wire logic        tx_baud_tick_o
);
  logic       wr_run;
  logic       wr_t2;
  logic [7:0] run_reg;
  logic [7:0] t2_reg;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Taken byte writes to the two control registers
  assign wr_run = cyc_i && stb_i && we_i && !ack_o && sel_i[0]
                  && adr_i == TCU_ADDR_RUN_CTRL;
  assign wr_t2  = cyc_i && stb_i && we_i && !ack_o && sel_i[0]
                  && adr_i == TCU_ADDR_T2_CTRL;

  // Shadow of the software-owned control bits
  always_ff @(posedge clk_i) begin
    if (rst_i)
      run_reg <= TCU_BYTE_RESET;
    else if (wr_run)
      run_reg <= dat_i[7:0];
  end
  always_ff @(posedge clk_i) begin
    if (rst_i)
      t2_reg <= TCU_BYTE_RESET;
    else if (wr_t2)
      t2_reg <= dat_i[7:0];
  end

  sequence s_taken;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_fall_one;
    run_reg[TCU_IT1] && $fell(ext_irq_one_pin_i);
  endsequence

  chk_ack_follows: assert property (s_taken |=> ack_o)
    else $error("request not acknowledged next cycle");
  chk_ack_single: assert property (ack_o |=> !ack_o)
    else $error("acknowledge longer than one cycle");
  chk_read_upper: assert property (ack_o |-> dat_o[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  chk_level_zero_set: assert property (
    (!run_reg[TCU_IT0] && !ext_irq_zero_pin_i && !wr_run) [*5]
    |-> ext_irq_zero_req_o) else $error("level flag zero not following pin");
  chk_level_one_clr: assert property (
    (!run_reg[TCU_IT1] && ext_irq_one_pin_i && !wr_run) [*5]
    |-> !ext_irq_one_req_o) else $error("level flag one set with pin high");
  chk_edge_one_set: assert property (
    s_fall_one |-> ##[1:5] ext_irq_one_req_o)
    else $error("edge on pin one not flagged");
  chk_rx_tick_sel: assert property (
    rx_baud_tick_o |-> t2_reg[TCU_RCLK] && t2_reg[TCU_TR2])
    else $error("receive tick without its select");
  chk_tx_tick_sel: assert property (
    tx_baud_tick_o |-> t2_reg[TCU_TRANSMIT_BAUD_CLOCK_SELECT] && t2_reg[TCU_TR2])
    else $error("transmit tick without its select");
  chk_tick_spacing: assert property (rx_baud_tick_o |=> !rx_baud_tick_o)
    else $error("baud ticks closer than two clocks");
  chk_t0_needs_run: assert property (
    $rose(timer_zero_req_o) && !$past(wr_run) |-> $past(run_reg[TCU_TR0]))
    else $error("timer zero overflow while stopped");
endmodule

bind tcu_top tcu_asserts #(.MACHINE_DIV(MACHINE_DIV)) tcu_asserts_i (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o),
  .ext_irq_zero_pin_i(ext_irq_zero_pin_i),
  .ext_irq_one_pin_i(ext_irq_one_pin_i),
  .ext_irq_zero_req_o(ext_irq_zero_req_o),
  .timer_zero_req_o(timer_zero_req_o),
  .ext_irq_one_req_o(ext_irq_one_req_o),
  .rx_baud_tick_o(rx_baud_tick_o), .tx_baud_tick_o(tx_baud_tick_o));
`default_nettype wire

// ===== tb/tcu_pins_model.sv
// Model of the pulled-up interrupt and trigger pins
`timescale 1ns/100ps
`default_nettype none
module tcu_pins_model #(
  parameter int FAST_LEN = 3,
  parameter int SLOW_LEN = 12
) (
  // Clock and requests
  input  wire logic       clk_i,
  input  wire logic       slow_i,
  input  wire logic [2:0] hold_i,
  input  wire logic [2:0] pulse_i,
  // Pins
  output logic      [2:0] pin_o
);
  logic [3:0] len_reg [3] = '{default: 4'h0};

  // A pulse keeps its pin low for a short or a long span
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 3; i++) begin
      if (pulse_i[i])
        len_reg[i] <= slow_i ? 4'(SLOW_LEN) : 4'(FAST_LEN);
      else if (len_reg[i] != 4'h0)
        len_reg[i] <= len_reg[i] - 4'h1;
    end
  end

  // Released lines return to the pull-up level
  always_comb begin
    for (int i = 0; i < 3; i++)
      pin_o[i] = !(hold_i[i] || len_reg[i] != 4'h0);
  end
endmodule
`default_nettype wire

// ===== tb/tcu_top_tb.sv
// Self-checking bench for the timer/counter unit
`timescale 1ns/100ps
`default_nettype none
module tcu_top_tb;
  import tcu_pkg::*;
  localparam int         MDIV = 2;
  localparam logic [3:0] ALL  = 4'hf;
  localparam logic [7:0] CNT [8] = '{TCU_ADDR_T0_LOW, TCU_ADDR_T0_HIGH,
    TCU_ADDR_T1_LOW, TCU_ADDR_T1_HIGH, TCU_ADDR_RCAP_LOW, TCU_ADDR_RCAP_HI,
    TCU_ADDR_T2_LOW, TCU_ADDR_T2_HIGH};
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  tcu_wb_req_s req   = '0;
  logic        slow  = 1'b0;
  logic [2:0]  hold  = 3'h0;
  logic [2:0]  pulse = 3'h0;
  logic [2:0]  pins;
  logic [6:0]  outs;
  logic [31:0] dat_o;
  logic        ack_o;
  logic [7:0]  q, r, lo, hi;
  int          mismatches = 0;
  int          compares = 0;
  int          rxn = 0;
  int          txn = 0;
  int          snap;

  always #25 clk_i = ~clk_i;

  tcu_top #(.MACHINE_DIV(MDIV)) tcu_top_i (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(req.cyc), .stb_i(req.stb),
    .we_i(req.we), .adr_i(req.adr), .sel_i(req.sel), .dat_i(req.dat),
    .dat_o(dat_o), .ack_o(ack_o), .ext_irq_zero_pin_i(pins[0]),
    .ext_irq_one_pin_i(pins[1]), .external_trigger_input_i(pins[2]),
    .ext_irq_zero_req_o(outs[0]), .timer_zero_req_o(outs[1]),
    .ext_irq_one_req_o(outs[2]), .timer_one_req_o(outs[3]),
    .third_timer_req_o(outs[4]), .rx_baud_tick_o(outs[5]),
    .tx_baud_tick_o(outs[6]));

  tcu_pins_model tcu_pins_model_i (.clk_i(clk_i), .slow_i(slow),
    .hold_i(hold), .pulse_i(pulse), .pin_o(pins));

  // Baud tick counters
  always @(posedge clk_i) begin
    if (outs[5] === 1'b1)
      rxn++;
    if (outs[6] === 1'b1)
      txn++;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One classic bus cycle; read data lands in q
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    input logic [3:0] s);
    @(posedge clk_i);
    req <= '{1'b1, 1'b1, w, a, s, {24'h00_0000, d}};
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o[7:0];
    req <= '0;
  endtask

  task automatic wait_hi(input int b);
    for (int n = 0; n < 600 && outs[b] !== 1'b1; n++)
      @(posedge clk_i);
  endtask

  task automatic kick(input int k);
    @(posedge clk_i);
    pulse[k] <= 1'b1;
    @(posedge clk_i);
    pulse[k] <= 1'b0;
    repeat (18) @(posedge clk_i);
  endtask

  task automatic summarize;
    if (mismatches == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    summarize();
  end

  initial begin
    r = 8'($urandom(32'h02aef34d));
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset value and an unmapped place
    wb(1'b0, TCU_ADDR_RUN_CTRL, 8'h00, ALL);
    chk(q, 8'h00);
    wb(1'b1, 8'hf0, 8'h5a, ALL);
    wb(1'b0, 8'hf0, 8'h00, ALL);
    chk(q, 8'h00);
    // Random count values; a write without lane zero is ignored
    foreach (CNT[i]) begin
      r = 8'($urandom);
      wb(1'b1, CNT[i], r, ALL);
      wb(1'b1, CNT[i], ~r, 4'he);
      wb(1'b0, CNT[i], 8'h00, ALL);
      chk(q, r);
    end
    // Basic timers in 16-bit and 8-bit form
    for (int t = 0; t < 2; t++) begin
      lo = t ? TCU_ADDR_T1_LOW : TCU_ADDR_T0_LOW;
      hi = t ? TCU_ADDR_T1_HIGH : TCU_ADDR_T0_HIGH;
      for (int m = 0; m < 2; m++) begin
        r = 8'h80 | 8'($urandom);
        wb(1'b1, TCU_ADDR_T01_MODE, m ? 8'h01 << t : 8'h00, ALL);
        wb(1'b1, lo, 8'hf8, ALL);
        wb(1'b1, hi, m ? r : 8'hff, ALL);
        wb(1'b1, TCU_ADDR_RUN_CTRL, 8'h10 << (2 * t), ALL);
        wait_hi(1 + 2 * t);
        chk({7'h0, outs[1 + 2 * t]}, 8'h01);
        wb(1'b0, hi, 8'h00, ALL);
        chk(q, m ? r : 8'h00);
        wb(1'b1, TCU_ADDR_VECTOR, 8'h02 << (2 * t), ALL);
        wb(1'b0, TCU_ADDR_RUN_CTRL, 8'h00, ALL);
        chk(q, 8'h10 << (2 * t));
        wb(1'b1, TCU_ADDR_RUN_CTRL, 8'h00, ALL);
        wb(1'b0, lo, 8'h00, ALL);
        r = q;
        repeat (20) @(posedge clk_i);
        wb(1'b0, lo, 8'h00, ALL);
        chk(q, r);
      end
    end
    // External pins: level follows the pin, edge latches
    for (int k = 0; k < 2; k++) begin
      slow = k[0];
      @(posedge clk_i);
      hold[k] <= 1'b1;
      repeat (8) @(posedge clk_i);
      wb(1'b1, TCU_ADDR_VECTOR, 8'h01 << (2 * k), ALL);
      chk({7'h0, outs[2 * k]}, 8'h01);
      hold[k] <= 1'b0;
      repeat (8) @(posedge clk_i);
      chk({7'h0, outs[2 * k]}, 8'h00);
      wb(1'b1, TCU_ADDR_RUN_CTRL, 8'h01 << (2 * k), ALL);
      kick(k);
      wb(1'b0, TCU_ADDR_RUN_CTRL, 8'h00, ALL);
      chk(q, 8'h03 << (2 * k));
      wb(1'b1, TCU_ADDR_VECTOR, 8'h01 << (2 * k), ALL);
      wb(1'b0, TCU_ADDR_RUN_CTRL, 8'h00, ALL);
      chk(q, 8'h01 << (2 * k));
      wb(1'b1, TCU_ADDR_RUN_CTRL, 8'h00, ALL);
    end
    // Third timer: autoreload, trigger reload, capture
    r = {1'b0, 7'($urandom)} | 8'h01;
    wb(1'b1, TCU_ADDR_RCAP_LOW, 8'h00, ALL);
    wb(1'b1, TCU_ADDR_RCAP_HI, r, ALL);
    wb(1'b1, TCU_ADDR_T2_LOW, 8'hfa, ALL);
    wb(1'b1, TCU_ADDR_T2_HIGH, 8'hff, ALL);
    wb(1'b1, TCU_ADDR_T2_CTRL, 8'h04, ALL);
    wait_hi(4);
    wb(1'b0, TCU_ADDR_T2_HIGH, 8'h00, ALL);
    chk(q, r);
    wb(1'b0, TCU_ADDR_T2_CTRL, 8'h00, ALL);
    chk(q, 8'h84);
    wb(1'b1, TCU_ADDR_T2_CTRL, 8'h0c, ALL);
    wb(1'b1, TCU_ADDR_T2_HIGH, ~r, ALL);
    kick(2);
    chk({7'h0, outs[4]}, 8'h01);
    wb(1'b0, TCU_ADDR_T2_HIGH, 8'h00, ALL);
    chk(q, r);
    wb(1'b1, TCU_ADDR_T2_CTRL, 8'h0d, ALL);
    wb(1'b1, TCU_ADDR_T2_HIGH, ~r, ALL);
    kick(2);
    wb(1'b0, TCU_ADDR_RCAP_HI, 8'h00, ALL);
    chk(q, ~r);
    wb(1'b0, TCU_ADDR_T2_CTRL, 8'h00, ALL);
    chk(q, 8'h4d);
    // Capture mode without trigger enable wraps on overflow
    wb(1'b1, TCU_ADDR_T2_CTRL, 8'h05, ALL);
    wb(1'b1, TCU_ADDR_T2_HIGH, 8'hff, ALL);
    wb(1'b1, TCU_ADDR_T2_LOW, 8'hf0, ALL);
    wait_hi(4);
    wb(1'b0, TCU_ADDR_T2_HIGH, 8'h00, ALL);
    chk(q, 8'h00);
    wb(1'b0, TCU_ADDR_T2_CTRL, 8'h00, ALL);
    chk(q, 8'h85);
    // Baud generator, receive then transmit select
    wb(1'b1, TCU_ADDR_T2_CTRL, 8'h00, ALL);
    foreach (CNT[i])
      if (i > 3)
        wb(1'b1, CNT[i], i[0] ? 8'hff : 8'hfc, ALL);
    wb(1'b1, TCU_ADDR_T2_CTRL, 8'h24, ALL);
    snap = rxn;
    txn = 0;
    repeat (80) @(posedge clk_i);
    chk({7'h0, rxn - snap inside {[9:11]}}, 8'h01);
    chk(8'(txn), 8'h00);
    wb(1'b1, TCU_ADDR_T2_CTRL, 8'h1c, ALL);
    snap = rxn;
    kick(2);
    chk({7'h0, txn > 0 && rxn == snap}, 8'h01);
    wb(1'b0, TCU_ADDR_T2_CTRL, 8'h00, ALL);
    chk(q, 8'h5c);
    summarize();
  end
endmodule
`default_nettype wire
